// [logic/crc8_step.sv]
`default_nettype none

`include "ocsc_params.svh"

// ----------------------------------------------------------------
// one serial step of the packet error check, msb first
// ----------------------------------------------------------------
module crc8_step (
  input  wire logic [7:0] crc_in,
  input  wire logic       bit_in,
  output logic      [7:0] crc_out
);

  // shift and fold in the polynomial on feedback
  always_comb begin
    crc_out = {crc_in[6:0], 1'b0};
    if (crc_in[7] ^ bit_in) begin
      crc_out = crc_out ^ `CRC_POLY;
    end
  end

endmodule

`default_nettype wire

// [logic/ocsc_params.svh]
`ifndef OCSC_PARAMS_SVH
`define OCSC_PARAMS_SVH

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define FRAME_BITS     5'h10
`define PEC_BITS       5'h18
`define CNT_LAST       5'h1f
`define HDR_LAST_BIT   5'h03
`define RD_START_EDGE  5'h05
`define RD_LAST_EDGE   5'h10
`define RD_BIT_BASE    5'h10
`define READ_MARK      2'h2

// ----------------------------------------------------------------
// control word field positions
// ----------------------------------------------------------------
`define F_ADDR_HI      15
`define F_ADDR_LO      13
`define F_RW           12
`define F_RANGE_HI     10
`define F_RANGE_LO     7
`define F_CLEAR_LEVEL_SELECT       6
`define F_OUTPUT_ENABLE_BIT        5
`define F_CLEAR        4
`define F_SENSE_RESISTOR_SELECT         3
`define F_SRST         2

// ----------------------------------------------------------------
// packet error check and reset values
// ----------------------------------------------------------------
`define CRC_POLY       8'h07
`define CRC_INIT       8'h00
`define CTRL_RESET     8'h00
`define WORD_RESET     16'h0000

`endif

// [logic/ocsc_pkg.sv]
`default_nettype none

package ocsc_pkg;

  // ----------------------------------------------------------------
  // decoded output range
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    RNG_4_20MA, RNG_0_20MA, RNG_0_24MA, RNG_PM20MA, RNG_PM24MA,
    RNG_0_5V, RNG_0_10V, RNG_PM5V, RNG_PM10V,
    RNG_0_6V, RNG_0_12V, RNG_PM6V, RNG_PM12V, RNG_PM2V5,
    RNG_3M92_20M4, RNG_0_20M4, RNG_0_24M5, RNG_INVALID
  } range_mode_t;

  typedef enum logic [1:0] {
    CLR_BOTTOM, CLR_MIDSCALE, CLR_ZERO_VOLT
  } clear_target_t;

  // stored control fields, soft reset bit is never stored
  typedef struct packed {
    logic [3:0] range_code_bits;
    logic       clear_level_select;
    logic       output_enable_bit;
    logic       clear_cmd;
    logic       sense_resistor_select;
  } ctrl_t;

  // configuration handed to the analog side
  typedef struct packed {
    range_mode_t   range_mode;
    logic          is_current;
    logic          is_bipolar;
    logic          internal_rsense;
    logic          range_invalid;
    logic          outputs_enabled;
    logic          clear_active;
    clear_target_t clear_target;
  } drive_cfg_t;

  // asynchronous inputs into the system clock domain
  typedef struct packed {
    logic       frame_tgl;
    logic       crc_tgl;
    logic       sync_n;
    logic       clear_pin;
    logic       clear_level_select_pin;
    logic       fault_open;
    logic       fault_short;
    logic       fault_temp;
    logic [2:0] address_strap_pins;
  } pin_bundle_t;

  typedef struct packed {
    logic [4:0]  cnt;
    logic [23:0] shift;
    logic [7:0]  crc;
    logic [3:0]  hdr;
  } frame_st_t;

  typedef struct packed {
    logic [15:0] word;
    logic        crc_bad;
    logic        frame_tgl;
    logic        crc_tgl;
  } hand_st_t;

  typedef struct packed {
    logic [4:0] rcnt;
    logic       oe;
    logic       dout;
  } sdo_st_t;

  typedef struct packed {
    ctrl_t       ctrl;
    logic        packet_error_check;
    logic        frame_seen;
    logic        crc_seen;
    logic [15:0] rb;
    drive_cfg_t  cfg;
    logic        alert;
  } main_st_t;

endpackage

`default_nettype wire

// [logic/output_config_serial_control.sv]
`default_nettype none

`include "ocsc_params.svh"

module output_config_serial_control (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               sclk,
  input  wire logic               sync_n,
  input  wire logic               sdin,
  output logic                    sdo_out,
  output logic                    sdo_oe,
  input  wire logic [2:0]         address_strap_pins,
  input  wire logic               clear_pin,
  input  wire logic               clear_level_select_pin,
  input  wire logic               fault_open,
  input  wire logic               fault_short,
  input  wire logic               fault_temp,
  output ocsc_pkg::drive_cfg_t    drive_cfg,
  output logic                    fault_alert_out,
  output logic                    fault_alert_oe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ocsc_pkg::frame_st_t   frame_reg;
  ocsc_pkg::frame_st_t   frame_next;
  ocsc_pkg::hand_st_t    hand_reg;
  ocsc_pkg::hand_st_t    hand_next;
  ocsc_pkg::sdo_st_t     sdo_reg;
  ocsc_pkg::sdo_st_t     sdo_next;
  ocsc_pkg::main_st_t    main_reg;
  ocsc_pkg::main_st_t    main_next;
  ocsc_pkg::pin_bundle_t pins_raw;
  ocsc_pkg::pin_bundle_t pins;
  logic                  frame_rst_n;
  logic [7:0]            crc_step;
  logic [23:0]           shift_in;
  logic [4:0]            cnt_in;

  // frame logic is held reset while sync is high
  assign frame_rst_n = rst_n & ~sync_n;
  // a cut frame hands no word over

  // ----------------------------------------------------------------
  // link domain: receive on falling edge
  // ----------------------------------------------------------------
  crc8_step u_crc (
    .crc_in  (frame_reg.crc),
    .bit_in  (sdin),
    .crc_out (crc_step)
  );

  assign shift_in = {frame_reg.shift[22:0], sdin};
  assign cnt_in   = (frame_reg.cnt == `CNT_LAST) ? `CNT_LAST : frame_reg.cnt + 5'h01;

  // shift register, bit count and header capture
  // header is address plus read flag
  always_comb begin
    frame_next       = frame_reg;
    frame_next.shift = shift_in;
    frame_next.cnt   = cnt_in;
    // check covers the first 16 bits
    if (frame_reg.cnt < `FRAME_BITS) begin
      frame_next.crc = crc_step;
    end
    if (frame_reg.cnt == `HDR_LAST_BIT) begin
      frame_next.hdr = shift_in[3:0];
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_reg <= '0;
    end else begin
      frame_reg <= frame_next;
    end
  end

  // word holds until the next toggle
  // hand-off of complete words and check results
  always_comb begin
    hand_next = hand_reg;
    if (cnt_in == `FRAME_BITS && frame_reg.cnt != `FRAME_BITS) begin
      hand_next.word      = shift_in[15:0];
      hand_next.frame_tgl = ~hand_reg.frame_tgl;
    end
    if (cnt_in == `PEC_BITS && frame_reg.cnt != `PEC_BITS) begin
      hand_next.crc_bad = (shift_in[7:0] != frame_reg.crc);
      hand_next.crc_tgl = ~hand_reg.crc_tgl;
    end
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      hand_reg <= '0;
    end else begin
      hand_reg <= hand_next;
    end
  end

  // ----------------------------------------------------------------
  // link domain: readback on rising edge
  // ----------------------------------------------------------------
  always_comb begin
    // bits 11..0 on rising edges 5..16
    sdo_next = sdo_reg;
    if (sdo_reg.rcnt != `CNT_LAST) begin
      sdo_next.rcnt = sdo_reg.rcnt + 5'h01;
    end
    if (sdo_next.rcnt == `RD_START_EDGE) begin
      // rb is held still by the system side while a frame runs
      if (frame_reg.hdr == {main_reg.rb[`F_ADDR_HI:`F_ADDR_LO], 1'b1}) begin
        sdo_next.oe = 1'b1;
      end
    end
    if (sdo_next.rcnt >= `RD_START_EDGE && sdo_next.rcnt <= `RD_LAST_EDGE) begin
      sdo_next.dout = main_reg.rb[4'(`RD_BIT_BASE - sdo_next.rcnt)];
    end else begin
      sdo_next.dout = 1'b0;
    end
  end

  // flops only, so no pin glitch
  // sync rising resets this state, which releases the pin
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_reg <= '0;
    end else begin
      sdo_reg <= sdo_next;
    end
  end

  assign sdo_out = sdo_reg.dout;
  assign sdo_oe  = sdo_reg.oe;

  // ----------------------------------------------------------------
  // crossing into the system clock domain
  // ----------------------------------------------------------------
  // gather pins and toggles
  always_comb begin
    pins_raw                    = '0;
    pins_raw.frame_tgl          = hand_reg.frame_tgl;
    pins_raw.crc_tgl            = hand_reg.crc_tgl;
    pins_raw.sync_n             = sync_n;
    pins_raw.clear_pin          = clear_pin;
    pins_raw.clear_level_select_pin         = clear_level_select_pin;
    pins_raw.fault_open         = fault_open;
    pins_raw.fault_short        = fault_short;
    pins_raw.fault_temp         = fault_temp;
    pins_raw.address_strap_pins = address_strap_pins;
  end

  // one shared synchroniser
  sync3 #(
    .W ($bits(ocsc_pkg::pin_bundle_t))
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins)
  );

  // ----------------------------------------------------------------
  // system domain: control word, status and decode
  // ----------------------------------------------------------------
  always_comb begin
    logic        frame_evt;
    logic        crc_evt;
    logic        addressed;
    logic        pec_clear;
    logic        clear_level_select_eff;
    logic [15:0] w;
    ocsc_pkg::range_mode_t rm;
    frame_evt  = 1'b0;
    crc_evt    = 1'b0;
    addressed  = 1'b0;
    pec_clear  = 1'b0;
    clear_level_select_eff = 1'b0;
    w          = hand_reg.word;
    rm         = ocsc_pkg::RNG_INVALID;
    main_next  = main_reg;

    // a seen toggle means a settled word
    // word events arrive as toggles
    frame_evt            = pins.frame_tgl != main_reg.frame_seen;
    crc_evt              = pins.crc_tgl != main_reg.crc_seen;
    main_next.frame_seen = pins.frame_tgl;
    main_next.crc_seen   = pins.crc_tgl;
    addressed            = w[`F_ADDR_HI:`F_ADDR_LO] == pins.address_strap_pins;

    // apply bits 10..2 whether or not the read flag is set
    if (frame_evt && addressed) begin
      if (w[`F_SRST]) begin
        main_next.ctrl = `CTRL_RESET;
        pec_clear      = 1'b1;
      end else begin
        main_next.ctrl.range_code_bits       = w[`F_RANGE_HI:`F_RANGE_LO];
        main_next.ctrl.clear_level_select    = w[`F_CLEAR_LEVEL_SELECT];
        main_next.ctrl.output_enable_bit     = w[`F_OUTPUT_ENABLE_BIT];
        main_next.ctrl.clear_cmd             = w[`F_CLEAR];
        main_next.ctrl.sense_resistor_select = w[`F_SENSE_RESISTOR_SELECT];
        pec_clear                            = w[`F_RW];
      end
    end

    // packet error flag, a new error wins over a clear
    // sticky until a read or soft reset
    if (pec_clear) begin
      main_next.packet_error_check = 1'b0;
    end
    if (crc_evt && hand_reg.crc_bad) begin
      main_next.packet_error_check = 1'b1;
    end

    // readback image, frozen while a frame is in progress
    // so the link never sees a torn word
    if (pins.sync_n) begin
      main_next.rb = {pins.address_strap_pins, `READ_MARK,
                      main_reg.ctrl.range_code_bits,
                      main_reg.ctrl.clear_level_select,
                      main_reg.ctrl.output_enable_bit,
                      main_reg.ctrl.sense_resistor_select,
                      main_reg.packet_error_check, pins.fault_temp,
                      pins.fault_open, pins.fault_short};
    end

    // range decode
    // 1101..1111 split on the select
    unique case ({main_reg.ctrl.sense_resistor_select, main_reg.ctrl.range_code_bits})
      5'h00, 5'h10: rm = ocsc_pkg::RNG_4_20MA;
      5'h01, 5'h11: rm = ocsc_pkg::RNG_0_20MA;
      5'h02, 5'h12: rm = ocsc_pkg::RNG_0_24MA;
      5'h03, 5'h13: rm = ocsc_pkg::RNG_PM20MA;
      5'h04, 5'h14: rm = ocsc_pkg::RNG_PM24MA;
      5'h05, 5'h15: rm = ocsc_pkg::RNG_0_5V;
      5'h06, 5'h16: rm = ocsc_pkg::RNG_0_10V;
      5'h07, 5'h17: rm = ocsc_pkg::RNG_PM5V;
      5'h08, 5'h18: rm = ocsc_pkg::RNG_PM10V;
      5'h09, 5'h19: rm = ocsc_pkg::RNG_0_6V;
      5'h0a, 5'h1a: rm = ocsc_pkg::RNG_0_12V;
      5'h0b, 5'h1b: rm = ocsc_pkg::RNG_PM6V;
      5'h0c, 5'h1c: rm = ocsc_pkg::RNG_PM12V;
      5'h0d:        rm = ocsc_pkg::RNG_PM2V5;
      5'h1d:        rm = ocsc_pkg::RNG_3M92_20M4;
      5'h1e:        rm = ocsc_pkg::RNG_0_20M4;
      5'h1f:        rm = ocsc_pkg::RNG_0_24M5;
      5'h0e, 5'h0f: rm = ocsc_pkg::RNG_INVALID;
    endcase
    main_next.cfg.range_mode      = rm;
    main_next.cfg.range_invalid   = rm == ocsc_pkg::RNG_INVALID;
    main_next.cfg.internal_rsense = main_reg.ctrl.sense_resistor_select;

    // range class
    // zero code is a current range
    unique case (rm)
      ocsc_pkg::RNG_4_20MA, ocsc_pkg::RNG_0_20MA, ocsc_pkg::RNG_0_24MA,
      ocsc_pkg::RNG_3M92_20M4, ocsc_pkg::RNG_0_20M4, ocsc_pkg::RNG_0_24M5: begin
        main_next.cfg.is_current = 1'b1;
        main_next.cfg.is_bipolar = 1'b0;
      end
      ocsc_pkg::RNG_PM20MA, ocsc_pkg::RNG_PM24MA: begin
        main_next.cfg.is_current = 1'b1;
        main_next.cfg.is_bipolar = 1'b1;
      end
      ocsc_pkg::RNG_PM5V, ocsc_pkg::RNG_PM10V, ocsc_pkg::RNG_PM6V,
      ocsc_pkg::RNG_PM12V, ocsc_pkg::RNG_PM2V5: begin
        main_next.cfg.is_current = 1'b0;
        main_next.cfg.is_bipolar = 1'b1;
      end
      default: begin
        main_next.cfg.is_current = 1'b0;
        main_next.cfg.is_bipolar = 1'b0;
      end
    endcase

    // enable, clear request and clear target
    // pin and bit are ored
    main_next.cfg.outputs_enabled = main_reg.ctrl.output_enable_bit;
    main_next.cfg.clear_active    = pins.clear_pin | main_reg.ctrl.clear_cmd;
    clear_level_select_eff                    = pins.clear_level_select_pin | main_reg.ctrl.clear_level_select;
    if (!clear_level_select_eff) begin
      main_next.cfg.clear_target = ocsc_pkg::CLR_BOTTOM;
    end else if (main_next.cfg.is_bipolar) begin
      main_next.cfg.clear_target = ocsc_pkg::CLR_ZERO_VOLT;
    end else begin
      main_next.cfg.clear_target = ocsc_pkg::CLR_MIDSCALE;
    end

    // any fault pulls the alert line
    // packet error counts as a fault
    main_next.alert = main_reg.packet_error_check | pins.fault_open | pins.fault_short | pins.fault_temp;
  end

  // power-on state: all fields zero except the current flag, outputs disabled
  // decode of code zero is a current range
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_reg                <= '0;
      main_reg.cfg.is_current <= 1'b1;
    end else begin
      main_reg <= main_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // registers or a constant only
  assign drive_cfg       = main_reg.cfg;
  assign fault_alert_oe  = main_reg.alert;
  assign fault_alert_out = 1'b0;                            // open drain only pulls low

endmodule

`default_nettype wire

// [logic/sync3.sv]
`default_nettype none

// ----------------------------------------------------------------
// three-stage synchroniser, output moves when stages two and three agree
// ----------------------------------------------------------------
module sync3 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t r_reg;
  sync_st_t r_next;

  // per-bit agreement filter
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.q[i] = r_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.q;

endmodule

`default_nettype wire

// [testbench/output_config_serial_control_monitor.sv]
`default_nettype none

module output_config_serial_control_monitor (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 sclk,
  input wire logic                 sync_n,
  input wire logic                 sdin,
  input wire logic                 sdo_out,
  input wire logic                 sdo_oe,
  input wire logic [2:0]           address_strap_pins,
  input wire logic                 clear_pin,
  input wire logic                 clear_level_select_pin,
  input wire logic                 fault_open,
  input wire logic                 fault_short,
  input wire logic                 fault_temp,
  input wire ocsc_pkg::drive_cfg_t drive_cfg,
  input wire logic                 fault_alert_out,
  input wire logic                 fault_alert_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] rise_cnt = 5'h00;
  logic [5:0] head;
  logic [7:0] idle_cnt;
  logic       any_fault;

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // any fault input raised
  assign any_fault = fault_open | fault_short | fault_temp;
  // rising serial edges seen in this frame
  always_ff @(posedge sclk or posedge sync_n) begin
    if (sync_n) rise_cnt <= 5'h00;
    else if (rise_cnt != 5'h1f) rise_cnt <= rise_cnt + 5'h01;
  end
  // leading bits of the frame: address and read flag
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) head <= 6'h00;
    else head <= {head[4:0], sdin};
  end
  // system clocks since frame sync went idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) idle_cnt <= 8'h00;
    else if (!sync_n) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_alert_open_drain: assert property (@(posedge clock) disable iff (!rst_n) fault_alert_out == 1'b0)
    else $error("alert line driven high");
  a_alert_on_fault: assert property (@(posedge clock) disable iff (!rst_n) any_fault [*8] |-> fault_alert_oe)
    else $error("fault held but alert not pulled");
  a_sdo_idle_released: assert property (@(posedge clock) disable iff (!rst_n) sync_n |-> !sdo_oe)
    else $error("data out driven outside a frame");
  a_oe_start_edge: assert property (@(posedge sclk) disable iff (sync_n) $rose(sdo_oe) |-> rise_cnt == 5'h05)
    else $error("data out enabled at wrong serial edge");
  a_oe_addressed: assert property (@(posedge sclk) disable iff (sync_n) rise_cnt == 5'h05 |->
    sdo_oe == (head[5:2] == {address_strap_pins, 1'b1}))
    else $error("data out enable does not match address and read flag");
  a_rb_pad_bit: assert property (@(posedge sclk) disable iff (sync_n) rise_cnt == 5'h05 && sdo_oe |-> !sdo_out)
    else $error("first readback bit not zero");
  a_invalid_ext_only: assert property (@(posedge clock) disable iff (!rst_n)
    drive_cfg.range_invalid |-> !drive_cfg.internal_rsense)
    else $error("invalid range flagged with internal resistor");
  a_current_decode: assert property (@(posedge clock) disable iff (!rst_n) !drive_cfg.range_invalid |->
    drive_cfg.is_current == (drive_cfg.range_mode <= ocsc_pkg::RNG_PM24MA || drive_cfg.range_mode >= ocsc_pkg::RNG_3M92_20M4))
    else $error("current flag disagrees with range");
  a_clear_zero_bipolar: assert property (@(posedge clock) disable iff (!rst_n)
    drive_cfg.clear_target == ocsc_pkg::CLR_ZERO_VOLT |-> drive_cfg.is_bipolar)
    else $error("zero volt clear in unipolar range");
  a_cfg_after_frame: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(drive_cfg.range_mode) |-> idle_cnt < 8'd20)
    else $error("range changed without a recent frame");

  c_read_frame: cover property (@(posedge sclk) rise_cnt == 5'h05 && sdo_oe);
  c_alert: cover property (@(posedge clock) fault_alert_oe);
  c_trim_range: cover property (@(posedge clock) drive_cfg.range_mode == ocsc_pkg::RNG_0_24M5);
endmodule

bind output_config_serial_control output_config_serial_control_monitor i_monitor (
  .clock(clock), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo_out(sdo_out),
  .sdo_oe(sdo_oe), .address_strap_pins(address_strap_pins), .clear_pin(clear_pin),
  .clear_level_select_pin(clear_level_select_pin), .fault_open(fault_open), .fault_short(fault_short), .fault_temp(fault_temp),
  .drive_cfg(drive_cfg), .fault_alert_out(fault_alert_out), .fault_alert_oe(fault_alert_oe)
);

`default_nettype wire

// [testbench/serial_host_model.sv]
`default_nettype none

module serial_host_model (
  output logic      sclk,
  output logic      sync_n,
  output logic      sdin,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // link clock stands still high between frames
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame at 15 ns per bit, readback and drive flag per rising edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic [23:0] w, input int n, output logic [15:0] rd, output logic [15:0] oev);
    rd = 16'h0000;
    oev = 16'h0000;
    #3.3 sync_n = 1'b0;
    for (int k = 1; k <= n; k++) begin
      sdin = w[n-k];
      #4.5 sclk = 1'b0;
      #7.5 sclk = 1'b1;
      #3;
      if (k <= 16) oev[k-1] = sdo_oe;
      if (k >= 5 && k <= 16) rd[16-k] = sdo_out;
    end
    #4 sync_n = 1'b1;
    sdin = ~sdin;  // released line shows the inverse of the last bit
  endtask
endmodule

`default_nettype wire

// [testbench/tb_output_config_serial_control.sv]
`default_nettype none

module tb_output_config_serial_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clock, rst_n, sclk, sync_n, sdin, sdo_out, sdo_oe, clear_pin, clear_level_select_pin;
  logic                 fault_open, fault_short, fault_temp, fault_alert_out, fault_alert_oe;
  logic [2:0]           address_strap_pins;
  logic [15:0]          rd, oev, exp_rb;
  logic [31:0]          r;
  ocsc_pkg::drive_cfg_t drive_cfg;
  int                   failures, tests_run, seed, m_rng, m_cs, m_oe, m_clr, m_rs, m_pec;

  output_config_serial_control i_output_config_serial_control (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .address_strap_pins(address_strap_pins), .clear_pin(clear_pin),
    .clear_level_select_pin(clear_level_select_pin), .fault_open(fault_open), .fault_short(fault_short), .fault_temp(fault_temp),
    .drive_cfg(drive_cfg), .fault_alert_out(fault_alert_out), .fault_alert_oe(fault_alert_oe)
  );
  serial_host_model i_serial_host_model (
    .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo_out(sdo_out), .sdo_oe(sdo_oe)
  );

  // ----------------------------------------------------------------
  // clock, comparison and closing
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  // expected configuration from the stored fields and the pins
  function automatic ocsc_pkg::drive_cfg_t model_cfg();
    ocsc_pkg::drive_cfg_t e;
    logic                 cur, bip;
    cur = (m_rng <= 4) || (m_rs == 1 && m_rng >= 13);
    bip = (m_rng == 3 || m_rng == 4) || (!cur && (m_rng == 7 || m_rng == 8 || m_rng >= 11));
    e.range_mode = ocsc_pkg::range_mode_t'(5'((m_rs == 1 && m_rng >= 13) ? m_rng + 1 : m_rng));
    e.is_current = cur;
    e.is_bipolar = bip;
    e.internal_rsense = 1'(m_rs);
    e.range_invalid = 1'b0;
    e.outputs_enabled = 1'(m_oe);
    e.clear_active = 1'(m_clr) | clear_pin;
    if (!(1'(m_cs) | clear_level_select_pin)) e.clear_target = ocsc_pkg::CLR_BOTTOM;
    else if (bip) e.clear_target = ocsc_pkg::CLR_ZERO_VOLT;
    else e.clear_target = ocsc_pkg::CLR_MIDSCALE;
    return e;
  endfunction
  // check byte, msb first, polynomial 0x07
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // ----------------------------------------------------------------
  // frame with optional check byte: 0 none, 1 good, 2 corrupted
  // ----------------------------------------------------------------
  task automatic send(input logic [15:0] w, input int crcm);
    logic [23:0] f;
    logic        hit;
    hit = (w[15:13] === address_strap_pins);
    exp_rb = {address_strap_pins, 2'b10, 4'(m_rng), 1'(m_cs), 1'(m_oe), 1'(m_rs), 1'(m_pec), fault_temp, fault_open,
              fault_short};
    f = (crcm == 0) ? {8'h00, w} : {w, crc8(w) ^ ((crcm == 2) ? 8'h01 : 8'h00)};
    i_serial_host_model.xfer(f, (crcm == 0) ? 16 : 24, rd, oev);
    check(32'(oev), (hit && w[12]) ? 32'hfff0 : 32'h0);
    if (hit && w[12]) check(32'(rd[11:0]), 32'(exp_rb[11:0]));
    if (hit) begin
      if (w[12]) m_pec = 0;
      {m_rng, m_cs, m_oe, m_clr, m_rs} = w[2] ? 0 : {int'(w[10:7]), int'(w[6]), int'(w[5]), int'(w[4]), int'(w[3])};
      if (w[2]) m_pec = 0;
      if (crcm == 2) m_pec = 1;
    end
    repeat (14) @(posedge clock);
    #1;
    check(32'(drive_cfg), 32'(model_cfg()));
    check(32'(sdo_oe), 32'h0);
    check(32'(fault_alert_oe), 32'(m_pec != 0 || fault_open || fault_short || fault_temp));
  endtask
  // pins change one small delay after the system clock edge
  task automatic set_pins(input logic [4:0] v);
    @(posedge clock);
    #1;
    {clear_pin, clear_level_select_pin, fault_open, fault_short, fault_temp} = v;
    repeat (6) @(posedge clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hd480;
    failures = 0;
    tests_run = 0;
    {m_rng, m_cs, m_oe, m_clr, m_rs, m_pec} = 0;
    rst_n = 1'b0;
    address_strap_pins = 3'($random(seed));
    {clear_pin, clear_level_select_pin, fault_open, fault_short, fault_temp} = 5'h00;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    check(32'(drive_cfg), 32'(model_cfg()));
    check(32'({sdo_oe, fault_alert_oe}), 32'h0);
    repeat (5) @(posedge clock);
    $display("test reset values done");
    for (int rs = 0; rs < 2; rs++) begin
      for (int code = 0; code < 16; code++) begin
        if (rs == 1 || code < 14) begin
          set_pins(5'($random(seed)));
          r = $random(seed);
          send({address_strap_pins, r[0], 1'b0, 4'(code), r[3:1], 1'(rs), 3'h0}, 0);
        end
      end
    end
    $display("test range sweep done");
    send({address_strap_pins ^ 3'h2, 1'b1, 1'b0, 4'h6, 3'h7, 1'b1, 3'h0}, 0);
    $display("test foreign address done");
    set_pins(5'h00);
    send({address_strap_pins, 1'b0, 1'b0, 4'h5, 3'h2, 1'b0, 3'h0}, 1);
    send({address_strap_pins, 1'b0, 1'b0, 4'h7, 3'h2, 1'b1, 3'h0}, 2);
    send({address_strap_pins, 1'b1, 1'b0, 4'h7, 3'h3, 1'b1, 3'h0}, 0);
    send({address_strap_pins, 1'b1, 1'b0, 4'h2, 3'h2, 1'b0, 3'h0}, 0);
    $display("test packet error done");
    send({address_strap_pins, 1'b1, 1'b0, 4'h9, 3'h7, 1'b1, 3'h4}, 1);
    send({address_strap_pins, 1'b1, 1'b0, 4'h0, 3'h0, 1'b0, 3'h0}, 0);
    $display("test soft reset done");
    tally_and_finish();
  end

  // frames take about 17 us in all; 300 us, over seventeen times that, is a hang
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
